// ===== rtl/xfer_pkg.sv
// shared constants and types for the image block transfer control
package xfer_pkg;
    localparam int DATA_W  = 32;
    localparam int QDEPTH  = 16;
    localparam int QAW     = 4;
    localparam int LVL_W   = 5;
    localparam int BLK_W   = 16;
    localparam int TALLY_W = 16;

    // register byte offsets on the wishbone slave
    localparam logic [7:0] ADDR_METHOD = 8'h00;
    localparam logic [7:0] ADDR_STYLE  = 8'h04;
    localparam logic [7:0] ADDR_BLOCKS = 8'h08;
    localparam logic [7:0] ADDR_CAP    = 8'h0C;
    localparam logic [7:0] ADDR_FILL   = 8'h10;
    localparam logic [7:0] ADDR_TALLY  = 8'h14;
    localparam logic [7:0] ADDR_ORDER  = 8'h18;
    localparam logic [7:0] ADDR_CMD    = 8'h1C;
    localparam logic [7:0] ADDR_STAT   = 8'h20;

    // command register bit positions
    localparam int GO_BIT   = 0;
    localparam int HALT_BIT = 1;

    localparam logic [LVL_W-1:0]   CAP_VALUE     = 5'h10;
    localparam logic [BLK_W-1:0]   BLOCKS_RESET  = 16'h0001;
    localparam logic [TALLY_W-1:0] TALLY_MAX     = 16'hFFFF;

    typedef enum logic [1:0] {
        basic_method,
        automatic_method,
        software_gated_method
    } xfer_method_t;

    typedef enum logic {
        continuous_run,
        fixed_count_run
    } xfer_run_style_t;

    typedef enum logic {
        oldest_first_order
    } queue_order_t;

    // one image block handle as it moves through the queue
    typedef struct packed {
        logic [DATA_W-1:0] payload;
    } blk_t;
endpackage : xfer_pkg

// ===== rtl/xfer_ctrl.sv
// transfer queue fifo and block transfer controller with wishbone registers
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns

// How it works
// - basic/automatic send as soon as data queued
// - user method: only go starts; halt, end of fixed count or channel close stops
// - continuous: stream nonstop while go is active
// - multi-block: user method sends exactly N, then stops
// - software-writable count of blocks to send
// - block count ignored unless multi-block style
// - read-only queue capacity in blocks
// - read-only live queue fill level
// - read-only count of dropped blocks
// - queue order select holds only oldest-first
// - go command starts streaming, user method only
// - halt command stops streaming, user method only
// - halt never cuts current block short
// - oldest queued block always goes next
// - full queue: overwrite oldest, count drop
// - channel close flushes queue and pending sends

module xfer_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          flush_i,
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    input  wire logic [W-1:0]  in_data_i,
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output logic [W-1:0]       out_data_o,
    output logic [AW:0]        level_o
);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic         push;
    logic         pop;
    logic         full;

    // extra pointer bit tells full from empty
    assign level_o     = wr_ptr - rd_ptr;
    assign full        = (level_o == (AW+1)'(DEPTH));
    assign out_valid_o = (level_o != '0);
    // a pop in the same cycle frees a slot, so a full queue still takes
    assign in_ready_o  = !full || out_ready_i;
    assign pop         = out_valid_o && out_ready_i;
    assign push        = in_valid_i && in_ready_o;
    assign out_data_o  = mem[rd_ptr[AW-1:0]]; // oldest entry at head

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // pointers; flush drops everything at once
    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : xfer_fifo

module xfer_ctrl (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [7:0]            adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    input  wire logic                  channel_open_i,
    input  wire logic                  blk_valid_i,
    input  wire xfer_pkg::blk_t        blk_i,
    output logic                       blk_ready_o,
    output logic                       stream_valid_o,
    output xfer_pkg::blk_t             stream_o,
    input  wire logic                  stream_ready_i
);
    import xfer_pkg::*;

    xfer_method_t          xfer_method_select;
    xfer_run_style_t       xfer_run_style;
    queue_order_t          queue_order_select;
    logic [BLK_W-1:0]      blocks_to_send;
    logic [BLK_W-1:0]      remaining;
    logic [TALLY_W-1:0]    dropped_block_tally;
    logic [LVL_W-1:0]      queue_fill_level;
    logic                  running;
    logic                  busy;
    logic                  wr;
    logic                  stream_go_cmd;
    logic                  stream_halt_cmd;
    logic                  gated;
    logic                  send_en;
    logic                  q_valid;
    logic                  q_ready;
    logic                  q_full;
    logic                  load;
    logic                  drop;
    logic                  sent;
    blk_t                  q_head;

    // merge write data into a register under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // a write lands on the edge where the master sees ack
    assign wr              = cyc_i && stb_i && we_i && ack_o;
    assign stream_go_cmd   = wr && (adr_i == ADDR_CMD) && sel_i[0] && dat_i[GO_BIT];
    assign stream_halt_cmd = wr && (adr_i == ADDR_CMD) && sel_i[0] && dat_i[HALT_BIT];
    assign gated           = (xfer_method_select == software_gated_method);

    // automatic methods always drain; software method waits for go
    assign send_en = !gated || running;
    assign q_full  = (queue_fill_level == CAP_VALUE);
    assign sent    = stream_valid_o && stream_ready_i;
    // next block enters the output stage only once the last is done
    assign load    = send_en && q_valid && !busy && channel_open_i;
    // overwrite oldest: pop the head while the new block is pushed
    assign drop    = blk_valid_i && q_full && !load && channel_open_i;
    assign q_ready = load || drop;
    assign blk_ready_o    = q_ready || !q_full;
    assign stream_valid_o = busy;

    xfer_fifo #(
        .W     (DATA_W),
        .DEPTH (QDEPTH),
        .AW    (QAW)
    ) u_queue (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (!channel_open_i),
        .in_valid_i  (blk_valid_i && channel_open_i),
        .in_ready_o  (),
        .in_data_i   (blk_i.payload),
        .out_valid_o (q_valid),
        .out_ready_i (q_ready),
        .out_data_o  (q_head.payload),
        .level_o     (queue_fill_level)
    );

    // wishbone ack: one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // read data registered with the ack; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (cyc_i && stb_i && !ack_o && !we_i) begin
            unique case (adr_i)
                ADDR_METHOD: dat_o <= 32'(xfer_method_select);
                ADDR_STYLE:  dat_o <= 32'(xfer_run_style);
                ADDR_BLOCKS: dat_o <= 32'(blocks_to_send);
                ADDR_CAP:    dat_o <= 32'(CAP_VALUE);
                ADDR_FILL:   dat_o <= 32'(queue_fill_level);
                ADDR_TALLY:  dat_o <= 32'(dropped_block_tally);
                ADDR_ORDER:  dat_o <= 32'(queue_order_select);
                ADDR_STAT:   dat_o <= {running, busy, 14'h0, remaining};
                default:     dat_o <= 32'h0;
            endcase
        end
    end

    // configuration registers; illegal codes are refused
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_method_select <= basic_method;
            xfer_run_style     <= continuous_run;
            blocks_to_send     <= BLOCKS_RESET;
            queue_order_select <= oldest_first_order;
        end else if (wr) begin
            if (adr_i == ADDR_METHOD && sel_i[0] && dat_i[1:0] != 2'h3) begin
                xfer_method_select <= xfer_method_t'(dat_i[1:0]);
            end
            if (adr_i == ADDR_STYLE && sel_i[0]) begin
                xfer_run_style <= xfer_run_style_t'(dat_i[0]);
            end
            if (adr_i == ADDR_BLOCKS) begin
                blocks_to_send <= merge(32'(blocks_to_send), dat_i, sel_i)
                                  [BLK_W-1:0];
            end
            // oldest-first is the only order; other codes leave it as is
            if (adr_i == ADDR_ORDER && sel_i[0] && dat_i[0] == 1'b0) begin
                queue_order_select <= oldest_first_order;
            end
        end
    end

    // run gate: commands count only under the software method
    always_ff @(posedge clk_i) begin
        if (rst_i || !channel_open_i || !gated) begin
            running <= 1'b0;
        end else if (stream_halt_cmd) begin
            running <= 1'b0;
        end else if (stream_go_cmd) begin
            // a zero count in fixed style sends nothing
            running <= (xfer_run_style == continuous_run)
                       || (blocks_to_send != '0);
        end else if (load && xfer_run_style == fixed_count_run
                     && remaining == 16'h0001) begin
            running <= 1'b0;
        end
    end

    // blocks left in a fixed-count run; unused in continuous style
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remaining <= '0;
        end else if (stream_go_cmd && gated) begin
            remaining <= blocks_to_send;
        end else if (load && gated && xfer_run_style == fixed_count_run) begin
            remaining <= remaining - 16'h0001;
        end
    end

    // output stage: one block held until the host takes it
    always_ff @(posedge clk_i) begin
        if (rst_i || !channel_open_i) begin
            busy <= 1'b0;
        end else if (load) begin
            busy <= 1'b1;
        end else if (sent) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stream_o <= '0;
        end else if (load) begin
            stream_o <= q_head;
        end
    end

    // drop tally saturates so software never sees it wrap to zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dropped_block_tally <= '0;
        end else if (drop && dropped_block_tally != TALLY_MAX) begin
            dropped_block_tally <= dropped_block_tally + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_go_fixed;
        stream_go_cmd && gated && xfer_run_style == fixed_count_run
            && !stream_halt_cmd && channel_open_i;
    endsequence

    AST_AUTO_SEND: assert property (
        (!gated && q_valid && !busy && channel_open_i) |=> busy)
        else $error("automatic method did not start a queued block");

    AST_GATED_HOLD: assert property (
        (gated && !running) |-> !load)
        else $error("block started without a go command");

    AST_CONT_KEEP: assert property (
        (gated && running && xfer_run_style == continuous_run
         && !stream_halt_cmd && channel_open_i
         && $stable(xfer_method_select)) |=> running)
        else $error("continuous run stopped by itself");

    AST_FIXED_END: assert property (
        (load && gated && xfer_run_style == fixed_count_run
         && remaining == 16'h0001 && !stream_go_cmd) |=> !running ##1 !load)
        else $error("fixed run did not stop after its last block");

    AST_GO_RELOAD: assert property (
        s_go_fixed |=> (remaining == $past(blocks_to_send)))
        else $error("go did not load the block count");

    AST_CAP_READ: assert property (
        (cyc_i && stb_i && !we_i && !ack_o && adr_i == ADDR_CAP)
        |=> ack_o && dat_o == 32'h0000_0010)
        else $error("capacity read wrong");

    AST_FILL_UP: assert property (
        (blk_valid_i && channel_open_i && !q_ready && !q_full)
        |=> queue_fill_level == $past(queue_fill_level) + 5'h01)
        else $error("fill level missed an enqueue");

    AST_DROP_COUNT: assert property (
        (drop && dropped_block_tally != TALLY_MAX)
        |=> dropped_block_tally == $past(dropped_block_tally) + 16'h0001
            && queue_fill_level == CAP_VALUE)
        else $error("overflow not counted");

    AST_HALT_FINISH: assert property (
        (busy && !stream_ready_i && channel_open_i) |=> busy
            && $stable(stream_o))
        else $error("block in flight was cut short");

    AST_CLOSE_FLUSH: assert property (
        !channel_open_i |=> queue_fill_level == '0 && !busy && !running)
        else $error("closing the channel left blocks pending");
endmodule : xfer_ctrl

// ===== tb/host_sink.sv
// host side model that takes blocks off the stream channel
`timescale 1ns/1ns
module host_sink (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hold_i,
    input  wire logic slow_i,
    output logic      stream_ready_o
);
    // a slow host drops ready every other cycle, hold models a stalled link
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stream_ready_o <= 1'b0;
        end else begin
            stream_ready_o <= !hold_i && (!slow_i || !stream_ready_o);
        end
    end
endmodule : host_sink

// ===== tb/image_block_transfer_control_tb.sv
// self-checking bench for the block transfer controller
`timescale 1ns/1ns
module image_block_transfer_control_tb;
    import xfer_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rnd;
    logic        blk_valid, blk_ready, channel_open;
    logic        stream_valid, stream_ready, hold, slow;
    blk_t        blk, stream;
    logic [31:0] exp_q[$];
    int          fails, samples_checked;

    xfer_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .channel_open_i(channel_open), .blk_valid_i(blk_valid), .blk_i(blk),
        .blk_ready_o(blk_ready), .stream_valid_o(stream_valid), .stream_o(stream),
        .stream_ready_i(stream_ready));
    host_sink u_host (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .slow_i(slow),
        .stream_ready_o(stream_ready));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task complete_run;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one classic cycle; the request stands until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, ack, 1'b1);
            complete_run;
        end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask : rd_chk

    // n blocks back to back; the first n_exp are expected on the stream
    task push(input int n, input int n_exp);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rnd = next_rand(rnd);
            blk_valid <= 1'b1;
            blk <= rnd;
            if (i < n_exp) exp_q.push_back(rnd);
        end
        @(posedge clk_i);
        blk_valid <= 1'b0;
    endtask : push

    task drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (exp_q.size() != 0) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, exp_q.size(), 0);
            complete_run;
        end
    endtask : drain

    // every block the host takes must be the oldest one noted
    always @(posedge clk_i) begin
        if (stream_valid === 1'b1 && stream_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("mismatch at %0t: got %h expected %h", $time, stream, 32'h0);
            end else begin
                check(stream.payload, exp_q.pop_front());
            end
        end
    end

    initial begin
        int n;
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        wdat = 32'h0; blk_valid = 1'b0; blk = '0; channel_open = 1'b1;
        hold = 1'b0; slow = 1'b0; rnd = 32'h0000DF0E;
        fails = 0; samples_checked = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(ADDR_METHOD, 32'h0);
        rd_chk(ADDR_BLOCKS, 32'h1);
        rd_chk(ADDR_CAP, 32'h10);
        rd_chk(ADDR_FILL, 32'h0);
        rd_chk(ADDR_TALLY, 32'h0);
        wb(1'b1, ADDR_ORDER, 32'h1);
        rd_chk(ADDR_ORDER, 32'h0);
        rd_chk(8'h40, 32'h0);
        $display("test reset_values done");
        // basic method streams at once, even to a slow host
        slow <= 1'b1;
        push(5, 5);
        drain;
        slow <= 1'b0;
        $display("test basic_stream done");
        // software gating: nothing moves until go, halt spares the loaded block
        wb(1'b1, ADDR_METHOD, 32'h2);
        hold <= 1'b1;
        push(1, 1);
        repeat (10) @(posedge clk_i);
        rd_chk(ADDR_FILL, 32'h1);
        wb(1'b1, ADDR_CMD, 32'h1);
        n = 0;
        while (stream_valid !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, stream_valid, 1'b1);
            complete_run;
        end
        wb(1'b1, ADDR_CMD, 32'h2);
        hold <= 1'b0;
        drain;
        push(1, 0);
        repeat (20) @(posedge clk_i);
        rd_chk(ADDR_FILL, 32'h1);
        channel_open <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd_chk(ADDR_FILL, 32'h0);
        channel_open <= 1'b1;
        $display("test gated_stream done");
        // fixed count sends exactly two, then idles while blocks pile up
        wb(1'b1, ADDR_STYLE, 32'h1);
        wb(1'b1, ADDR_BLOCKS, 32'h2);
        push(4, 2);
        wb(1'b1, ADDR_CMD, 32'h1);
        drain;
        repeat (20) @(posedge clk_i);
        rd_chk(ADDR_FILL, 32'h2);
        rd_chk(ADDR_STAT, 32'h0);
        $display("test fixed_count done");
        // two blocks beyond capacity displace the two oldest
        push(16, 0);
        rd_chk(ADDR_FILL, 32'h10);
        rd_chk(ADDR_TALLY, 32'h2);
        check(32'(blk_ready), 32'h0);
        $display("test overflow done");
        complete_run;
    end
endmodule : image_block_transfer_control_tb
